//--- hdl/wfd_regs.svh
// register offsets, field positions, reset values and counts of the wake detector
// assumes byte addressing on a 32-bit Avalon-MM slave
`ifndef WFD_REGS_SVH
`define WFD_REGS_SVH
// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define WFD_ADDR_CTRL      8'h00
`define WFD_ADDR_PORT      8'h04
`define WFD_ADDR_MAC_LO    8'h08
`define WFD_ADDR_MAC_HI    8'h0C
// ------------------------------------------------------------
// wake_control_status fields
// ------------------------------------------------------------
`define WFD_CS_MP_EN       1
`define WFD_CS_WAKE_EN     2
`define WFD_CS_MP_RCV      4
`define WFD_CS_FR_RCV      5
`define WFD_CS_GUNI        9
`define WFD_CS_MP_IRQ      10
`define WFD_CS_RESET       32'h0000_0000
`define WFD_CS_VALID       32'h0000_0636
`define WFD_CS_W1C         32'h0000_0030
// ------------------------------------------------------------
// pattern filter port layout
// ------------------------------------------------------------
`define WFD_W_CMD          3'h4
`define WFD_W_OFF          3'h5
`define WFD_W_CRC01        3'h6
`define WFD_W_CRC23        3'h7
`define WFD_MASK_VALID     32'h7FFF_FFFF
`define WFD_CMD_VALID      32'h0909_0909
`define WFD_CMD_EN         0
`define WFD_CMD_ATYPE      3
`define WFD_MASK_LEN       10'h01F
`define WFD_FILT_RESET     32'h0000_0000
// ------------------------------------------------------------
// frame processing constants
// ------------------------------------------------------------
`define WFD_CRC_INIT       16'hFFFF
`define WFD_CRC_POLY       16'h8005
`define WFD_SYNC_BYTE      8'hFF
`define WFD_SYNC_LEN       3'h6
`define WFD_MAC_LAST       3'h5
`define WFD_COPY_LAST      4'hF
`define WFD_DA_LEN         10'h006
`define WFD_POS_MAX        10'h3FF
`endif

//--- hdl/wfd_pkg.sv
// types shared by the wake frame detector
// assumes the constants of wfd_regs.svh
package wfd_pkg;
    typedef enum logic [2:0]
    {
        WFD_MP_SYNC = 3'b001,
        WFD_MP_ADDR = 3'b010,
        WFD_MP_DONE = 3'b100
    } wfd_mp_state_t;
    typedef logic [15:0] wfd_crc_t;
    typedef logic [9:0]  wfd_pos_t;
endpackage

//--- hdl/wfd_wakeup_frame_detector.sv
// wake frame detector: pattern filters and address-repetition scanner
// assumes rx bytes synchronous to ref_clk, one byte per rx_valid, rx_sof/rx_eof with it
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`include "wfd_regs.svh"

module wfd_wakeup_frame_detector
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // receive byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic        rx_addr_pass,
    // wake outputs
    output logic             rx_suppress,
    output logic             wake_event,
    output logic             pattern_frame_received,
    output logic             address_pattern_received
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic wfd_pkg::wfd_crc_t crc16_byte(input wfd_pkg::wfd_crc_t c, input logic [7:0] d);
        wfd_pkg::wfd_crc_t r;
        r = c;
        for (int k = 7; k >= 0; k--)
        begin
            if (r[15] ^ d[k])
                r = {r[14:0], 1'b0} ^ `WFD_CRC_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [31:0] cs_r, cs_nxt;
    logic [31:0] filt_r [8];
    logic [31:0] filt_nxt [8];
    logic [2:0]  ptr_r, ptr_nxt;
    logic [31:0] mac_lo_r, mac_lo_nxt;
    logic [31:0] mac_hi_r, mac_hi_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wait_r, wait_nxt;
    logic        supp_r, supp_nxt;
    logic        wake_r, wake_nxt;
    logic        acc, wr_go;
    logic        fr_set, mp_set;

    assign acc   = (avs_read | avs_write) & wait_r;
    assign wr_go = avs_write & ~wait_r;

    // ------------------------------------------------------------
    // frame position and address class
    // ------------------------------------------------------------
    wfd_pkg::wfd_pos_t pos_r, pos_nxt, pos_now;
    logic        mc_r, mc_nxt, bc_r, bc_nxt;
    logic        mc_now, bc_now, uc_now;
    logic        byte_ok;

    assign byte_ok = rx_valid;
    assign pos_now = rx_sof ? '0 : pos_r;

    always_comb
    begin
        pos_nxt = pos_r;
        mc_nxt  = mc_r;
        bc_nxt  = bc_r;
        mc_now  = mc_r;
        bc_now  = bc_r;
        if (byte_ok && pos_now < `WFD_DA_LEN)
        begin
            if (pos_now == '0)
            begin
                mc_now = rx_data[0];
                bc_now = (rx_data == `WFD_SYNC_BYTE);
            end
            else
                bc_now = bc_r & (rx_data == `WFD_SYNC_BYTE);
        end
        if (byte_ok)
        begin
            mc_nxt  = mc_now;
            bc_nxt  = bc_now;
            pos_nxt = (pos_now == `WFD_POS_MAX) ? pos_now : pos_now + 10'h001;
        end
    end
    assign uc_now = ~mc_now;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pos_r <= '0;
            mc_r  <= 1'b0;
            bc_r  <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            mc_r  <= mc_nxt;
            bc_r  <= bc_nxt;
        end
    end

    // ------------------------------------------------------------
    // pattern filters
    // ------------------------------------------------------------
    wfd_pkg::wfd_crc_t crc_r [4];
    wfd_pkg::wfd_crc_t crc_nxt [4];
    logic [3:0]  hit;

    always_comb
    begin
        hit = '0;
        for (int i = 0; i < 4; i++)
        begin
            wfd_pkg::wfd_crc_t c;
            wfd_pkg::wfd_crc_t exp_crc;
            wfd_pkg::wfd_pos_t rel;
            logic [7:0]  off;
            logic [7:0]  cmd;
            logic        sel;
            c       = rx_sof ? `WFD_CRC_INIT : crc_r[i];
            off     = filt_r[`WFD_W_OFF][i*8 +: 8];
            cmd     = filt_r[`WFD_W_CMD][i*8 +: 8];
            exp_crc = filt_r[`WFD_W_CRC01 + 3'(i/2)][(i%2)*16 +: 16];
            rel     = pos_now - {2'b00, off};
            sel     = (pos_now >= {2'b00, off}) && (rel < `WFD_MASK_LEN)
                      && filt_r[3'(i)][rel[4:0]];
            crc_nxt[i] = (byte_ok && sel) ? crc16_byte(c, rx_data) : c;
            if (!byte_ok)
                crc_nxt[i] = crc_r[i];
            // broadcast, global unicast, or address-filter pass with matching type
            if (byte_ok && rx_eof && cmd[`WFD_CMD_EN] && crc_nxt[i] == exp_crc)
                hit[i] = bc_now
                         | (uc_now & cs_r[`WFD_CS_GUNI])
                         | (rx_addr_pass & mc_now & ~bc_now & cmd[`WFD_CMD_ATYPE])
                         | (rx_addr_pass & uc_now & ~cmd[`WFD_CMD_ATYPE]);
        end
    end
    assign fr_set = cs_r[`WFD_CS_WAKE_EN] & (|hit);

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (reset)
                crc_r[i] <= `WFD_CRC_INIT;
            else
                crc_r[i] <= crc_nxt[i];
        end
    end

    // ------------------------------------------------------------
    // address-repetition scanner
    // ------------------------------------------------------------
    wfd_pkg::wfd_mp_state_t mp_r, mp_nxt, mp_now;
    logic [2:0]  sync_r, sync_nxt;
    logic [2:0]  idx_r, idx_nxt;
    logic [3:0]  copy_r, copy_nxt;
    logic [47:0] mac48;
    logic        is_ff, is_mac;

    assign mac48  = {mac_hi_r[15:0], mac_lo_r};
    assign is_ff  = (rx_data == `WFD_SYNC_BYTE);
    assign is_mac = (rx_data == mac48[idx_r*8 +: 8]);
    assign mp_now = rx_sof ? wfd_pkg::WFD_MP_SYNC : mp_r;

    // no power-state input: scanning depends only on the enable
    always_comb
    begin
        mp_nxt   = mp_r;
        sync_nxt = sync_r;
        idx_nxt  = idx_r;
        copy_nxt = copy_r;
        mp_set   = 1'b0;
        if (byte_ok && cs_r[`WFD_CS_MP_EN])
        begin
            case (mp_now)
                wfd_pkg::WFD_MP_SYNC:
                begin
                    logic [2:0] s;
                    s = rx_sof ? 3'h0 : sync_r;
                    // any byte position, destination class ignored
                    sync_nxt = is_ff ? s + 3'h1 : 3'h0;
                    idx_nxt  = 3'h0;
                    copy_nxt = 4'h0;
                    mp_nxt   = (is_ff && s + 3'h1 == `WFD_SYNC_LEN) ? wfd_pkg::WFD_MP_ADDR
                                                                    : wfd_pkg::WFD_MP_SYNC;
                end
                wfd_pkg::WFD_MP_ADDR:
                begin
                    if (is_mac)
                    begin
                        idx_nxt = (idx_r == `WFD_MAC_LAST) ? 3'h0 : idx_r + 3'h1;
                        if (idx_r == `WFD_MAC_LAST)
                        begin
                            copy_nxt = copy_r + 4'h1;
                            if (copy_r == `WFD_COPY_LAST)
                            begin
                                mp_nxt = wfd_pkg::WFD_MP_DONE;
                                mp_set = 1'b1;
                            end
                        end
                    end
                    else if (!(is_ff && idx_r == 3'h0 && copy_r == 4'h0))
                    begin
                        mp_nxt   = wfd_pkg::WFD_MP_SYNC;
                        sync_nxt = is_ff ? 3'h1 : 3'h0;
                    end
                end
                wfd_pkg::WFD_MP_DONE:
                    mp_nxt = wfd_pkg::WFD_MP_DONE;
                default:
                    mp_nxt = wfd_pkg::WFD_MP_SYNC;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mp_r   <= wfd_pkg::WFD_MP_SYNC;
            sync_r <= 3'h0;
            idx_r  <= 3'h0;
            copy_r <= 4'h0;
        end
        else
        begin
            mp_r   <= mp_nxt;
            sync_r <= sync_nxt;
            idx_r  <= idx_nxt;
            copy_r <= copy_nxt;
        end
    end

    // ------------------------------------------------------------
    // register file and bus slave
    // ------------------------------------------------------------
    // waitrequest drops for one cycle after a request is seen, so every access takes two cycles
    always_comb
    begin
        cs_nxt     = cs_r;
        ptr_nxt    = ptr_r;
        mac_lo_nxt = mac_lo_r;
        mac_hi_nxt = mac_hi_r;
        rdata_nxt  = rdata_r;
        wait_nxt   = ~acc;
        for (int w = 0; w < 8; w++)
            filt_nxt[w] = filt_r[w];
        if (acc && avs_read)
        begin
            case (avs_address)
                `WFD_ADDR_CTRL:   rdata_nxt = cs_r;
                `WFD_ADDR_PORT:   rdata_nxt = filt_r[ptr_r];
                `WFD_ADDR_MAC_LO: rdata_nxt = mac_lo_r;
                `WFD_ADDR_MAC_HI: rdata_nxt = mac_hi_r;
                default:          rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (wr_go)
        begin
            case (avs_address)
                `WFD_ADDR_CTRL:
                begin
                    logic [31:0] m;
                    m      = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
                    cs_nxt = (be_merge(cs_r, avs_writedata, avs_byteenable) & `WFD_CS_VALID
                              & ~`WFD_CS_W1C) | (cs_r & `WFD_CS_W1C & ~m);
                end
                `WFD_ADDR_PORT:
                begin
                    // successive words go masks, commands, offsets, CRC pairs
                    filt_nxt[ptr_r] = be_merge(filt_r[ptr_r], avs_writedata, avs_byteenable)
                                      & ((ptr_r < `WFD_W_CMD) ? `WFD_MASK_VALID
                                      : (ptr_r == `WFD_W_CMD) ? `WFD_CMD_VALID : 32'hFFFF_FFFF);
                    ptr_nxt = ptr_r + 3'h1;
                end
                `WFD_ADDR_MAC_LO: mac_lo_nxt = be_merge(mac_lo_r, avs_writedata, avs_byteenable);
                `WFD_ADDR_MAC_HI: mac_hi_nxt = be_merge(mac_hi_r, avs_writedata, avs_byteenable)
                                               & 32'h0000_FFFF;
                default:          ptr_nxt = ptr_r;
            endcase
        end
        // hardware set beats software clear in the same cycle
        if (fr_set)
            cs_nxt[`WFD_CS_FR_RCV] = 1'b1;
        if (mp_set)
            cs_nxt[`WFD_CS_MP_RCV] = 1'b1;
        supp_nxt = cs_nxt[`WFD_CS_MP_EN] | cs_nxt[`WFD_CS_WAKE_EN];
        wake_nxt = fr_set | (mp_set & cs_r[`WFD_CS_MP_IRQ]);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cs_r     <= `WFD_CS_RESET;
            ptr_r    <= 3'h0;
            mac_lo_r <= 32'h0000_0000;
            mac_hi_r <= 32'h0000_0000;
            rdata_r  <= 32'h0000_0000;
            wait_r   <= 1'b1;
            supp_r   <= 1'b0;
            wake_r   <= 1'b0;
            for (int w = 0; w < 8; w++)
                filt_r[w] <= `WFD_FILT_RESET;
        end
        else
        begin
            cs_r     <= cs_nxt;
            ptr_r    <= ptr_nxt;
            mac_lo_r <= mac_lo_nxt;
            mac_hi_r <= mac_hi_nxt;
            rdata_r  <= rdata_nxt;
            wait_r   <= wait_nxt;
            supp_r   <= supp_nxt;
            wake_r   <= wake_nxt;
            for (int w = 0; w < 8; w++)
                filt_r[w] <= filt_nxt[w];
        end
    end

    assign avs_readdata             = rdata_r;
    assign avs_waitrequest          = wait_r;
    assign rx_suppress              = supp_r;
    assign wake_event               = wake_r;
    assign pattern_frame_received   = cs_r[`WFD_CS_FR_RCV];
    assign address_pattern_received = cs_r[`WFD_CS_MP_RCV];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    mask_rsvd_a: assert property (!filt_r[0][31] && !filt_r[3][31])
        else $error("reserved mask bit stored");
    atype_mc_a: assert property (hit[2] && mc_now && !bc_now
                                 |-> filt_r[`WFD_W_CMD][16 + `WFD_CMD_ATYPE])
        else $error("multicast hit with unicast address type");
    dis_nowake_a: assert property (!filt_r[`WFD_W_CMD][16 + `WFD_CMD_EN] |-> !hit[2])
        else $error("disabled filter hit");
    bcast_wake_a: assert property (hit[0] && bc_now && cs_r[`WFD_CS_WAKE_EN]
                                   |=> wake_event && pattern_frame_received)
        else $error("broadcast pattern produced no wake");
    uc_wake_a: assert property (byte_ok && rx_eof && uc_now && cs_r[`WFD_CS_GUNI]
                                && filt_r[`WFD_W_CMD][8 + `WFD_CMD_EN]
                                && crc_nxt[1] == filt_r[`WFD_W_CRC01][31:16] |-> hit[1])
        else $error("unicast wake missed");
    scan_supp_a: assert property (cs_r[`WFD_CS_MP_EN] |-> rx_suppress)
        else $error("scan mode left reception on");
    resume_rx_a: assert property ($fell(cs_r[`WFD_CS_MP_EN]) && !cs_r[`WFD_CS_WAKE_EN]
                                  |-> !rx_suppress)
        else $error("reception not resumed");
    mp_flag_a: assert property (mp_set |=> address_pattern_received
                                && mp_r == wfd_pkg::WFD_MP_DONE)
        else $error("address pattern flag not set");
    mp_count_a: assert property (mp_set |-> copy_r == `WFD_COPY_LAST && idx_r == `WFD_MAC_LAST)
        else $error("detection before sixteen copies");
    mp_irq_a: assert property (mp_set && cs_r[`WFD_CS_MP_IRQ] |=> wake_event ##1 !wake_event)
        else $error("wake interrupt not one pulse");
    mp_restart_a: assert property (byte_ok && !rx_sof && cs_r[`WFD_CS_MP_EN]
                                   && mp_r == wfd_pkg::WFD_MP_ADDR && !is_mac && !is_ff
                                   |=> mp_r == wfd_pkg::WFD_MP_SYNC && sync_r == 3'h0)
        else $error("broken copy run not restarted");
    sticky_a: assert property (pattern_frame_received && !(wr_go && avs_address == `WFD_ADDR_CTRL)
                               |=> pattern_frame_received)
        else $error("received flag lost");
    bus_ack_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");

    mp_seen_c:  cover property (mp_set);
    pat_seen_c: cover property (fr_set);
    rd_acc_c:   cover property (avs_read && !avs_waitrequest);
    port_wr_c:  cover property (wr_go && avs_address == `WFD_ADDR_PORT && ptr_r == `WFD_W_CRC23);
endmodule

//--- verification/wfd_rx_source.sv
// receive datapath model feeding frame bytes to the wake detector
// assumes the bench calls send_frame only after reset is released
`timescale 1ns/10ps
module wfd_rx_source
(
    // clock
    input  wire logic       ref_clk,
    // byte stream
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic            rx_addr_pass
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_addr_pass = 1'b0;
    end
    // gaps every fifth byte; idle data flips so a stale byte never looks valid
    task automatic send_frame(input logic [7:0] q[$], input logic pass);
        for (int i = 0; i < q.size(); i++)
        begin
            @(posedge ref_clk);
            if (i % 5 == 4)
            begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                @(posedge ref_clk);
            end
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_sof <= (i == 0);
            rx_eof <= (i == q.size() - 1);
            rx_addr_pass <= pass;
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

//--- verification/wfd_wakeup_frame_detector_bench.sv
// self-checking bench of the wake frame detector
// assumes the detector answers every bus access after one wait cycle
`timescale 1ns/10ps
`include "wfd_regs.svh"
module wfd_wakeup_frame_detector_bench;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_valid, rx_sof, rx_eof, rx_addr_pass;
    logic [7:0]  rx_data;
    logic        rx_suppress, wake_event, pfr, apr;
    int          errors = 0;
    int          checks = 0;
    int          wakes = 0;
    logic [31:0] rd, cv;
    logic [15:0] c0, c1, c2;
    logic [7:0]  fr[$];
    logic [47:0] sta = 48'h02A1B2C3D4E5;
    logic [47:0] uni = 48'h020000000001;
    logic [47:0] mc = 48'h01AB5ECD0001;

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (wake_event === 1'b1) wakes <= wakes + 1;

    wfd_wakeup_frame_detector DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_addr_pass(rx_addr_pass),
        .rx_suppress(rx_suppress), .wake_event(wake_event), .pattern_frame_received(pfr),
        .address_pattern_received(apr));
    wfd_rx_source rx (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
        .rx_eof(rx_eof), .rx_addr_pass(rx_addr_pass));

    // ------------------------------------------------------------
    // compare, bus and frame helpers
    // ------------------------------------------------------------
    task complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask
    task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // msb-first crc over masked bytes of fr
    function automatic logic [15:0] crc(input int off, input logic [30:0] m);
        logic [15:0] c;
        logic        fb;
        c = 16'hFFFF;
        for (int i = 0; i < 31; i++)
            if (m[i])
                for (int k = 7; k >= 0; k--)
                begin
                    fb = c[15] ^ fr[off + i][k];
                    c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
                end
        return c;
    endfunction
    task mk(input logic [47:0] da);
        fr = {};
        for (int i = 5; i >= 0; i--) fr.push_back(da[i*8 +: 8]);
        for (int i = 0; i < 54; i++) fr.push_back(8'h40 + 8'(i));
    endtask
    task add_copies(input int n);
        for (int i = 0; i < 6; i++) fr.push_back(8'hFF);
        for (int i = 0; i < n * 6; i++) fr.push_back(sta[(5 - i % 6) * 8 +: 8]);
    endtask
    task load(input logic [7:0] cmd2);
        logic [31:0] fw[8];
        fw = '{32'h8000003F, 32'h3F, 32'h5, 32'h0, {8'h00, cmd2, 16'h0101}, 32'h00010000, {c1, c0}, {16'h0, c2}};
        for (int i = 0; i < 8; i++) av(1'b1, `WFD_ADDR_PORT, fw[i]);
        // pointer has wrapped to mask 0; the reserved bit must not have been stored
        av(1'b0, `WFD_ADDR_PORT, 32'h0);
        chk32(rd, 32'h0000003F);
    endtask
    // send fr, judge the pulse and the chosen flag, then clear both flags
    task try(input logic pass, input logic exp, input logic sel);
        int w0;
        w0 = wakes;
        rx.send_frame(fr, pass);
        repeat (3) @(posedge ref_clk);
        chk1(wakes != w0, exp);
        chk1(sel ? apr : pfr, exp);
        av(1'b1, `WFD_ADDR_CTRL, cv | 32'h30);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task test_regs;
        av(1'b0, `WFD_ADDR_CTRL, 32'h0);
        chk32(rd, 32'h0);
        av(1'b1, 8'h10, 32'hFFFFFFFF);
        av(1'b0, 8'h10, 32'h0);
        chk32(rd, 32'h0);
        av(1'b1, `WFD_ADDR_CTRL, 32'hFFFFFFFF);
        av(1'b0, `WFD_ADDR_CTRL, 32'h0);
        chk32(rd, 32'h606);
        chk1(rx_suppress, 1'b1);
        $display("test regs done");
    endtask
    task test_pattern;
        mk(48'hFFFFFFFFFFFF);
        c0 = crc(0, 31'h3F);
        mk(mc);
        c2 = crc(1, 31'h5);
        mk(uni);
        c1 = crc(0, 31'h3F);
        cv = 32'h4;
        av(1'b1, `WFD_ADDR_CTRL, cv);
        load(8'h08);
        try(1'b0, 1'b0, 1'b0);
        try(1'b1, 1'b1, 1'b0);
        cv = 32'h204;
        av(1'b1, `WFD_ADDR_CTRL, cv);
        try(1'b0, 1'b1, 1'b0);
        mk(48'hFFFFFFFFFFFF);
        try(1'b0, 1'b1, 1'b0);
        mk(mc);
        try(1'b1, 1'b0, 1'b0);
        load(8'h09);
        try(1'b1, 1'b1, 1'b0);
        load(8'h01);
        try(1'b1, 1'b0, 1'b0);
        $display("test pattern done");
    endtask
    task test_addr_rep;
        av(1'b1, `WFD_ADDR_MAC_LO, 32'hC3B2A102);
        av(1'b1, `WFD_ADDR_MAC_HI, 32'h0000E5D4);
        av(1'b0, `WFD_ADDR_MAC_HI, 32'h0);
        chk32(rd, 32'h0000E5D4);
        cv = 32'h402;
        av(1'b1, `WFD_ADDR_CTRL, cv);
        mk(mc);
        add_copies(15);
        fr.push_back(8'h00);
        add_copies(15);
        try(1'b0, 1'b0, 1'b1);
        mk(mc);
        add_copies(15);
        fr.push_back(8'h77);
        add_copies(16);
        fr.push_back(8'h12);
        try(1'b0, 1'b1, 1'b1);
        cv = 32'h0;
        av(1'b1, `WFD_ADDR_CTRL, cv);
        av(1'b0, `WFD_ADDR_CTRL, 32'h0);
        chk32(rd, 32'h0);
        chk1(rx_suppress, 1'b0);
        $display("test addr rep done");
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        test_regs;
        test_pattern;
        test_addr_rep;
        complete_run;
    end
    initial
    begin
        #40000;
        errors++;
        complete_run;
    end
endmodule
